//--- common/sbm_consts.svh
`ifndef SBM_CONSTS_SVH
`define SBM_CONSTS_SVH

// register pointers
`define SBM_PTR_CONFIG 8'h00
`define SBM_PTR_SHUNT 8'h01

// configuration register layout and reset value
`define SBM_CFG_RESET 16'h399F
`define SBM_CFG_SWRST_BIT 15
`define SBM_GAIN_HI 12
`define SBM_GAIN_LO 11
`define SBM_BUSSET_HI 10
`define SBM_BUSSET_LO 7
`define SBM_SHSET_HI 6
`define SBM_SHSET_LO 3
`define SBM_MODE_HI 2
`define SBM_MODE_LO 0

// operating-mode codes
`define SBM_MODE_PWRDN 3'h0
`define SBM_MODE_TRIG_SH 3'h1
`define SBM_MODE_TRIG_BUS 3'h2
`define SBM_MODE_TRIG_BOTH 3'h3
`define SBM_MODE_OFF 3'h4
`define SBM_MODE_CONT_SH 3'h5
`define SBM_MODE_CONT_BUS 3'h6
`define SBM_MODE_CONT_BOTH 3'h7

// full scale at unity gain, in 10 uV steps; doubles per gain code
`define SBM_FS_UNITY 16'h0FA0

// clock and conversion times
`define SBM_CLK_NS 20.0
`define SBM_T_9B_US 84.0
`define SBM_T_10B_US 148.0
`define SBM_T_11B_US 276.0
`define SBM_T_12B_US 532.0
`define SBM_T_AVG2_MS 1.06
`define SBM_T_AVG4_MS 2.13
`define SBM_T_AVG8_MS 4.26
`define SBM_T_AVG16_MS 8.51
`define SBM_T_AVG32_MS 17.02
`define SBM_T_AVG64_MS 34.05
`define SBM_T_AVG128_MS 68.10

`endif

//--- common/sbm_pkg.sv
package sbm_pkg;
    typedef enum logic [1:0] {
        SBM_IDLE,
        SBM_SHUNT,
        SBM_BUS
    } sbm_state_t;
    typedef logic [21:0] sbm_count_t;
endpackage : sbm_pkg

//--- logic/sbm_shunt_bus_measure_config.sv
`timescale 1ns/100ps
`include "sbm_consts.svh"
module sbm_shunt_bus_measure_config #(
    parameter int unsigned CYC_9B = int'(`SBM_T_9B_US * 1000.0 / `SBM_CLK_NS),
    parameter int unsigned CYC_10B = int'(`SBM_T_10B_US * 1000.0 / `SBM_CLK_NS),
    parameter int unsigned CYC_11B = int'(`SBM_T_11B_US * 1000.0 / `SBM_CLK_NS),
    parameter int unsigned CYC_12B = int'(`SBM_T_12B_US * 1000.0 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG2 = int'(`SBM_T_AVG2_MS * 1.0e6 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG4 = int'(`SBM_T_AVG4_MS * 1.0e6 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG8 = int'(`SBM_T_AVG8_MS * 1.0e6 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG16 = int'(`SBM_T_AVG16_MS * 1.0e6 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG32 = int'(`SBM_T_AVG32_MS * 1.0e6 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG64 = int'(`SBM_T_AVG64_MS * 1.0e6 / `SBM_CLK_NS),
    parameter int unsigned CYC_AVG128 = int'(`SBM_T_AVG128_MS * 1.0e6 / `SBM_CLK_NS)
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] regPtr,
    input wire logic regWrStb,
    input wire logic [15:0] regWrData,
    input wire logic signed [15:0] shuntSample,
    output logic [15:0] regRdData_r,
    output logic shuntConvOn_r,
    output logic busConvOn_r,
    output logic powerDown_r,
    output logic shuntLatched_r,
    output logic busLatched_r
);

    logic [15:0] cfg_r;
    logic [15:0] shuntRes_r;
    logic trigPend_r;
    sbm_pkg::sbm_state_t state_r;
    sbm_pkg::sbm_count_t cnt_r;
    logic cfgWr;
    logic softRst;
    logic [2:0] opMode;
    logic [1:0] gainSel;
    logic [3:0] shuntSet;
    logic [3:0] busSet;
    logic contMode;
    logic goNow;
    logic shuntEnd;
    logic busEnd;

    // conversion length in cycles, one less than the time for the down-counter
    function automatic sbm_pkg::sbm_count_t convCycles(input logic [3:0] code);
        int unsigned c;
        c = CYC_12B;
        if (!code[3])
        begin
            case (code[1:0])
                2'h0: c = CYC_9B;
                2'h1: c = CYC_10B;
                2'h2: c = CYC_11B;
                default: c = CYC_12B;
            endcase
        end
        else
        begin
            case (code[2:0])
                3'h0: c = CYC_12B;
                3'h1: c = CYC_AVG2;
                3'h2: c = CYC_AVG4;
                3'h3: c = CYC_AVG8;
                3'h4: c = CYC_AVG16;
                3'h5: c = CYC_AVG32;
                3'h6: c = CYC_AVG64;
                default: c = CYC_AVG128;
            endcase
        end
        return sbm_pkg::sbm_count_t'(c - 1);
    endfunction : convCycles

    // clamp to the gain range; the 16-bit signed value carries its own sign copies
    function automatic logic [15:0] shuntFmt(input logic signed [15:0] v, input logic [1:0] g);
        logic signed [15:0] lim;
        lim = signed'(16'(`SBM_FS_UNITY << g));
        if (v > lim)
            return lim;
        else if (v < -lim)
            return 16'(-lim);
        else
            return v;
    endfunction : shuntFmt

    assign cfgWr = regWrStb && (regPtr == `SBM_PTR_CONFIG);
    assign softRst = cfgWr && regWrData[`SBM_CFG_SWRST_BIT];
    assign opMode = cfg_r[`SBM_MODE_HI:`SBM_MODE_LO];
    assign gainSel = cfg_r[`SBM_GAIN_HI:`SBM_GAIN_LO];
    assign shuntSet = cfg_r[`SBM_SHSET_HI:`SBM_SHSET_LO];
    assign busSet = cfg_r[`SBM_BUSSET_HI:`SBM_BUSSET_LO];
    assign contMode = opMode[2] && (opMode[1:0] != 2'h0);
    assign goNow = (state_r == sbm_pkg::SBM_IDLE) && !cfgWr && (contMode || trigPend_r);
    assign shuntEnd = (state_r == sbm_pkg::SBM_SHUNT) && (cnt_r == '0) && !cfgWr;
    assign busEnd = (state_r == sbm_pkg::SBM_BUS) && (cnt_r == '0) && !cfgWr;

    // configuration; reset bit self-clears and reloads defaults
    always_ff @(posedge core_clk)
    begin
        if (!nrst || softRst)
            cfg_r <= `SBM_CFG_RESET;
        else if (cfgWr)
            cfg_r <= {1'b0, regWrData[14:0]};
    end

    // pending trigger: a write of a triggered mode arms one sequence
    always_ff @(posedge core_clk)
    begin
        if (!nrst || softRst)
            trigPend_r <= 1'b0;
        else if (cfgWr && !regWrData[2] && (regWrData[1:0] != 2'h0))
            trigPend_r <= 1'b1;
        else if (goNow)
            trigPend_r <= 1'b0;
    end

    // conversion sequencer; any configuration write restarts from idle
    always_ff @(posedge core_clk)
    begin
        if (!nrst || cfgWr)
        begin
            state_r <= sbm_pkg::SBM_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                sbm_pkg::SBM_IDLE:
                begin
                    if (goNow && opMode[0])
                    begin
                        state_r <= sbm_pkg::SBM_SHUNT;
                        cnt_r <= convCycles(shuntSet);
                    end
                    else if (goNow && opMode[1])
                    begin
                        state_r <= sbm_pkg::SBM_BUS;
                        cnt_r <= convCycles(busSet);
                    end
                end
                sbm_pkg::SBM_SHUNT:
                begin
                    if (cnt_r != '0)
                        cnt_r <= cnt_r - 1'b1;
                    else if (opMode[1])
                    begin
                        state_r <= sbm_pkg::SBM_BUS;
                        cnt_r <= convCycles(busSet);
                    end
                    else
                        state_r <= sbm_pkg::SBM_IDLE;
                end
                sbm_pkg::SBM_BUS:
                begin
                    if (cnt_r != '0)
                        cnt_r <= cnt_r - 1'b1;
                    else
                        state_r <= sbm_pkg::SBM_IDLE;
                end
                default: state_r <= sbm_pkg::SBM_IDLE;
            endcase
        end
    end

    // shunt result, kept across idle periods
    always_ff @(posedge core_clk)
    begin
        if (!nrst || softRst)
            shuntRes_r <= 16'h0000;
        else if (shuntEnd)
            shuntRes_r <= shuntFmt(shuntSample, gainSel);
    end

    // read data follows the pointer one cycle later
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            regRdData_r <= 16'h0000;
        else if (regPtr == `SBM_PTR_CONFIG)
            regRdData_r <= cfg_r;
        else if (regPtr == `SBM_PTR_SHUNT)
            regRdData_r <= shuntRes_r;
        else
            regRdData_r <= 16'h0000;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            shuntConvOn_r <= 1'b0;
            busConvOn_r <= 1'b0;
            powerDown_r <= 1'b0;
            shuntLatched_r <= 1'b0;
            busLatched_r <= 1'b0;
        end
        else
        begin
            shuntConvOn_r <= (state_r == sbm_pkg::SBM_SHUNT);
            busConvOn_r <= (state_r == sbm_pkg::SBM_BUS);
            powerDown_r <= (opMode == `SBM_MODE_PWRDN);
            shuntLatched_r <= shuntEnd;
            busLatched_r <= busEnd;
        end
    end

    a_mode_after_reset: assert property (@(posedge core_clk)
        !nrst |=> cfg_r[2:0] == `SBM_MODE_CONT_BOTH && cfg_r[12:11] == 2'h3)
        else $error("mode or gain not at default after reset");

    a_soft_reset: assert property (@(posedge core_clk) disable iff (!nrst)
        softRst |=> cfg_r == `SBM_CFG_RESET && shuntRes_r == 16'h0000)
        else $error("software reset did not restore defaults");

    a_short_conv_time: assert property (@(posedge core_clk) disable iff (!nrst)
        (goNow && opMode[0] && shuntSet[3] == 1'b0 && shuntSet[1:0] == 2'h0)
        |=> cnt_r == sbm_pkg::sbm_count_t'(CYC_9B - 1))
        else $error("9-bit conversion length wrong");

    a_avg_conv_time: assert property (@(posedge core_clk) disable iff (!nrst)
        (goNow && opMode[0] && shuntSet == 4'hF)
        |=> cnt_r == sbm_pkg::sbm_count_t'(CYC_AVG128 - 1))
        else $error("128-sample conversion length wrong");

    a_pwrdn_no_conv: assert property (@(posedge core_clk) disable iff (!nrst)
        (opMode == `SBM_MODE_PWRDN) [*2] |-> !shuntConvOn_r && !busConvOn_r && powerDown_r)
        else $error("conversion active in power-down");

    a_cont_restart: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == sbm_pkg::SBM_IDLE && opMode == `SBM_MODE_CONT_BOTH && !cfgWr)
        |=> state_r == sbm_pkg::SBM_SHUNT ##1 shuntConvOn_r)
        else $error("continuous mode did not restart");

    a_trig_stays_idle: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_r == sbm_pkg::SBM_IDLE && !trigPend_r && !contMode && !cfgWr)
        |=> state_r == sbm_pkg::SBM_IDLE)
        else $error("triggered mode converted without a new trigger");

    a_result_format: assert property (@(posedge core_clk) disable iff (!nrst)
        (shuntEnd && !softRst) |=> shuntRes_r == shuntFmt($past(shuntSample), $past(gainSel)))
        else $error("shunt result not formatted from sample");

    a_clamp_div8_neg: assert property (@(posedge core_clk) disable iff (!nrst)
        (shuntEnd && !softRst && gainSel == 2'h3 && shuntSample < -16'sd32000)
        |=> shuntRes_r == 16'h8300)
        else $error("div8 negative clamp wrong");

    a_clamp_unity_pos: assert property (@(posedge core_clk) disable iff (!nrst)
        (shuntEnd && !softRst && gainSel == 2'h0 && shuntSample > 16'sd4000)
        |=> shuntRes_r == 16'h0FA0 && shuntLatched_r)
        else $error("unity positive clamp wrong");

    a_sign_copies: assert property (@(posedge core_clk) disable iff (!nrst)
        (shuntEnd && !softRst && gainSel == 2'h1)
        |=> shuntRes_r[15:13] == 3'h0 || shuntRes_r[15:13] == 3'h7)
        else $error("div2 sign copies differ");

    a_read_shunt: assert property (@(posedge core_clk) disable iff (!nrst)
        (regPtr == `SBM_PTR_SHUNT) |=> regRdData_r == $past(shuntRes_r))
        else $error("shunt read returned wrong word");

endmodule : sbm_shunt_bus_measure_config

//--- testbench/sbm_host_model.sv
`timescale 1ns/100ps
module sbm_host_model (
    input wire logic core_clk,
    output logic [7:0] regPtr,
    output logic regWrStb,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData_r
);
    initial
    begin
        regPtr = 8'h00;
        regWrStb = 1'b0;
        regWrData = 16'h0000;
    end
    // data lines show the inverse once the strobe has gone
    task automatic wr(input logic [7:0] ptr, input logic [15:0] data);
        @(negedge core_clk);
        regPtr = ptr;
        regWrData = data;
        regWrStb = 1'b1;
        @(negedge core_clk);
        regWrStb = 1'b0;
        regWrData = ~data;
    endtask : wr
    task automatic rd(input logic [7:0] ptr, output logic [15:0] data);
        @(negedge core_clk);
        regPtr = ptr;
        @(negedge core_clk);
        data = regRdData_r;
    endtask : rd
endmodule : sbm_host_model

//--- testbench/sbm_shunt_bus_measure_config_bench.sv
`timescale 1ns/100ps
module sbm_shunt_bus_measure_config_bench;
    logic core_clk;
    logic nrst;
    logic signed [15:0] shuntSample;
    logic [7:0] regPtr;
    logic regWrStb;
    logic [15:0] regWrData;
    logic [15:0] regRdData_r;
    logic shuntConvOn_r, busConvOn_r, powerDown_r, shuntLatched_r, busLatched_r;
    logic pd;
    logic [15:0] rdv;
    int errors, nTests, sc, bc, sl, bl;
    // shortened conversion lengths in cycles, one per setting code class
    localparam int unsigned CYC9 = 3, CYC10 = 4, CYC11 = 5, CYC12 = 6;
    localparam int unsigned AVG2 = 7, AVG4 = 8, AVG8 = 9, AVG16 = 10;
    localparam int unsigned AVG32 = 11, AVG64 = 12, AVG128 = 13;

    sbm_shunt_bus_measure_config #(
        .CYC_9B(CYC9), .CYC_10B(CYC10), .CYC_11B(CYC11), .CYC_12B(CYC12),
        .CYC_AVG2(AVG2), .CYC_AVG4(AVG4), .CYC_AVG8(AVG8), .CYC_AVG16(AVG16),
        .CYC_AVG32(AVG32), .CYC_AVG64(AVG64), .CYC_AVG128(AVG128)
    ) sbm_shunt_bus_measure_config_inst (
        .core_clk(core_clk), .nrst(nrst), .regPtr(regPtr), .regWrStb(regWrStb),
        .regWrData(regWrData), .shuntSample(shuntSample), .regRdData_r(regRdData_r),
        .shuntConvOn_r(shuntConvOn_r), .busConvOn_r(busConvOn_r), .powerDown_r(powerDown_r),
        .shuntLatched_r(shuntLatched_r), .busLatched_r(busLatched_r)
    );
    sbm_host_model sbm_host_model_inst (
        .core_clk(core_clk), .regPtr(regPtr), .regWrStb(regWrStb),
        .regWrData(regWrData), .regRdData_r(regRdData_r)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        nTests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // park in power-down first so no earlier conversion spills into the window
    task automatic run(input logic [15:0] cfg);
        sbm_host_model_inst.wr(8'h00, {cfg[15:3], 3'h0});
        repeat (3) @(negedge core_clk);
        sbm_host_model_inst.wr(8'h00, cfg);
        sc = 0;
        bc = 0;
        sl = 0;
        bl = 0;
        repeat (40)
        begin
            sc += int'(shuntConvOn_r);
            bc += int'(busConvOn_r);
            sl += int'(shuntLatched_r);
            bl += int'(busLatched_r);
            @(negedge core_clk);
        end
        pd = powerDown_r;
    endtask : run

    task automatic t_regs;
        sbm_host_model_inst.rd(8'h00, rdv);
        chk("config after reset", 16'h399F, rdv);
        sbm_host_model_inst.rd(8'h01, rdv);
        chk("shunt after reset", 16'h0000, rdv);
        repeat (20) @(negedge core_clk);
        sbm_host_model_inst.rd(8'h01, rdv);
        chk("shunt continuous", 16'h0100, rdv);
        sbm_host_model_inst.wr(8'h00, 16'h8000);
        sbm_host_model_inst.rd(8'h01, rdv);
        chk("shunt after soft reset", 16'h0000, rdv);
        sbm_host_model_inst.wr(8'h00, 16'h3998);
        sbm_host_model_inst.wr(8'h01, 16'h1234);
        sbm_host_model_inst.rd(8'h01, rdv);
        chk("read-only shunt", 16'h0000, rdv);
        sbm_host_model_inst.rd(8'h05, rdv);
        chk("unmapped pointer", 16'h0000, rdv);
    endtask : t_regs

    // other channel's field holds a different code to catch swapped fields
    task automatic t_conv_time;
        int par [16];
        par = '{CYC9, CYC10, CYC11, CYC12, CYC9, CYC10, CYC11, CYC12,
            CYC12, AVG2, AVG4, AVG8, AVG16, AVG32, AVG64, AVG128};
        for (int c = 0; c < 16; c++)
        begin
            run(16'h1801 | 16'((15 - c) << 7) | 16'(c << 3));
            chk("shunt conv cycles", 16'(par[c]), 16'(sc));
            run(16'h1802 | 16'(c << 7) | 16'((15 - c) << 3));
            chk("bus conv cycles", 16'(par[c]), 16'(bc));
        end
    endtask : t_conv_time

    task automatic fmt(input int g, input logic [15:0] s, input logic [15:0] exp);
        shuntSample = s;
        run(16'h0001 | 16'(g << 11));
        sbm_host_model_inst.rd(8'h01, rdv);
        chk("shunt word", exp, rdv);
    endtask : fmt

    task automatic t_format;
        logic [15:0] pos [4];
        logic [15:0] neg [4];
        int fs;
        pos = '{16'h0FA0, 16'h1F40, 16'h3E80, 16'h7D00};
        neg = '{16'hF060, 16'hE0C0, 16'hC180, 16'h8300};
        for (int g = 0; g < 4; g++)
        begin
            fs = 4000 << g;
            fmt(g, 16'(fs), pos[g]);
            fmt(g, 16'(-fs), neg[g]);
            fmt(g, 16'(fs + 1), pos[g]);
            fmt(g, 16'(-fs - 1), neg[g]);
            fmt(g, 16'h7FFF, pos[g]);
            fmt(g, 16'hFFFF, 16'hFFFF);
            fmt(g, 16'h0F9F, 16'h0F9F);
        end
    endtask : t_format

    // 2 stands for two or more results in the window
    task automatic t_modes;
        int exSl [8];
        int exBl [8];
        exSl = '{0, 1, 0, 1, 0, 2, 0, 2};
        exBl = '{0, 0, 1, 1, 0, 0, 2, 2};
        shuntSample = 16'sh0123;
        for (int m = 0; m < 8; m++)
        begin
            run(16'h1800 | 16'(m));
            chk("shunt results", 16'(exSl[m]), 16'(sl > 2 ? 2 : sl));
            chk("bus results", 16'(exBl[m]), 16'(bl > 2 ? 2 : bl));
            chk("power-down", 16'(m == 0), 16'(pd));
        end
    endtask : t_modes

    task automatic testDone;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : testDone

    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        $display("watchdog expired");
        testDone;
    end

    initial
    begin
        errors = 0;
        nTests = 0;
        nrst = 1'b0;
        shuntSample = 16'sh0100;
        repeat (8) @(negedge core_clk);
        nrst = 1'b1;
        t_regs;
        $display("register test done");
        t_conv_time;
        $display("conversion time test done");
        t_format;
        $display("shunt format test done");
        t_modes;
        $display("mode test done");
        testDone;
    end
endmodule : sbm_shunt_bus_measure_config_bench
